/* File: logic/ufs_pkg.sv */
/*
  Constants of the UART FIFO shadow control block: register offsets,
  field positions, reset values and trigger encodings.
  Assumes a plain register port that compares full 32-bit byte addresses.
*/
package ufs_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned LEVEL_W = 5;
  localparam logic [LEVEL_W-1:0] FIFO_DEPTH = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_DMA_MODE = 32'h50001194;
  localparam logic [ADDR_W-1:0] OFS_FIFO_EN = 32'h50001198;
  localparam logic [ADDR_W-1:0] OFS_RX_THR = 32'h5000119c;
  localparam logic [ADDR_W-1:0] OFS_TX_THR = 32'h500011a0;
  localparam logic [ADDR_W-1:0] OFS_TX_HOLD = 32'h500011a4;
  localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 32'h500011a8;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK = 32'h500011ac;
  localparam logic [ADDR_W-1:0] OFS_BUILD = 32'h500011f4;
  localparam logic [ADDR_W-1:0] OFS_VERSION = 32'h500011f8;
  localparam logic [ADDR_W-1:0] OFS_TYPE = 32'h500011fc;
  // Control word field positions.
  localparam int unsigned FCW_FIFO_EN = 0;
  localparam int unsigned FCW_DMA_MODE = 3;
  localparam int unsigned FCW_TX_THR_LO = 4;
  localparam int unsigned FCW_RX_THR_LO = 6;
  localparam logic [7:0] FCW_RESET = 8'h00;
  // Build word reset value; version and type values are arbitrary.
  localparam logic [DATA_W-1:0] BUILD_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] VERSION_ID = 16'h0a51;
  localparam logic [DATA_W-1:0] TYPE_ID = 16'h0b62;
  // Interrupt status bit positions.
  localparam int unsigned IRQ_RX_AVAIL = 0;
  localparam int unsigned IRQ_TX_EMPTY = 1;
  localparam int unsigned IRQ_FIFO_RST = 2;
  localparam int unsigned IRQ_W = 3;
  localparam logic [1:0] TRIG_00 = 2'h0;
  localparam logic [1:0] TRIG_01 = 2'h1;
  localparam logic [1:0] TRIG_10 = 2'h2;
  localparam logic [1:0] TRIG_11 = 2'h3;
endpackage

/* File: logic/ufs_shadow.sv */
/*
  UART FIFO shadow controls: mirror registers, the FIFO control word,
  trigger decode, DMA receive request, transmit halt and interrupts.
  Assumes FIFO fill levels and the transmit-start request come from UART logic on the same clock.
*/
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ufs_shadow (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [ufs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ufs_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [ufs_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [ufs_pkg::LEVEL_W-1:0] rx_level,
  input wire logic [ufs_pkg::LEVEL_W-1:0] tx_level,
  input wire logic tx_start_request,
  output logic [7:0] fifo_control_word,
  output logic fifo_reset_pulse,
  output logic tx_start_allowed,
  output logic rx_trigger_hit,
  output logic transmit_holding_empty_event,
  output logic dma_rx_req_n,
  output logic irq
);
  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_meta_n, rst_sync_n;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic wr_dma, wr_fe, wr_rx, wr_tx, wr_hold, wr_stat, wr_mask;
  assign wr_dma = reg_write && (reg_addr == ufs_pkg::OFS_DMA_MODE);
  assign wr_fe = reg_write && (reg_addr == ufs_pkg::OFS_FIFO_EN);
  assign wr_rx = reg_write && (reg_addr == ufs_pkg::OFS_RX_THR);
  assign wr_tx = reg_write && (reg_addr == ufs_pkg::OFS_TX_THR);
  assign wr_hold = reg_write && (reg_addr == ufs_pkg::OFS_TX_HOLD);
  assign wr_stat = reg_write && (reg_addr == ufs_pkg::OFS_INT_STATUS);
  assign wr_mask = reg_write && (reg_addr == ufs_pkg::OFS_INT_MASK);

  // ---------------------------------------------------------------
  // FIFO control word
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fifo_control_word <= ufs_pkg::FCW_RESET;
    end else begin
      if (wr_dma) begin
        fifo_control_word[ufs_pkg::FCW_DMA_MODE] <= reg_wdata[0];
      end
      if (wr_fe) begin
        fifo_control_word[ufs_pkg::FCW_FIFO_EN] <= reg_wdata[0];
      end
      if (wr_rx) begin
        fifo_control_word[ufs_pkg::FCW_RX_THR_LO +: 2] <= reg_wdata[1:0];
      end
      if (wr_tx) begin
        fifo_control_word[ufs_pkg::FCW_TX_THR_LO +: 2] <= reg_wdata[1:0];
      end
    end
  end

  logic fifo_en, dma_mode;
  logic [1:0] rx_thr, tx_thr;
  assign fifo_en = fifo_control_word[ufs_pkg::FCW_FIFO_EN];
  assign dma_mode = fifo_control_word[ufs_pkg::FCW_DMA_MODE];
  assign rx_thr = fifo_control_word[ufs_pkg::FCW_RX_THR_LO +: 2];
  assign tx_thr = fifo_control_word[ufs_pkg::FCW_TX_THR_LO +: 2];

  // Falling FIFO enable resets both FIFO controllers for one cycle.
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fifo_reset_pulse <= 1'b0;
    end else begin
      fifo_reset_pulse <= wr_fe && fifo_en && !reg_wdata[0];
    end
  end

  // ---------------------------------------------------------------
  // Transmit halt
  // ---------------------------------------------------------------
  logic tx_hold;
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tx_hold <= 1'b0;
    end else if (wr_hold) begin
      tx_hold <= reg_wdata[0];
    end
  end
  assign tx_start_allowed = tx_start_request && !(tx_hold && fifo_en);

  // ---------------------------------------------------------------
  // Trigger decode
  // ---------------------------------------------------------------
  logic [ufs_pkg::LEVEL_W-1:0] rx_mark, tx_mark;
  logic rx_at_mark;
  assign rx_at_mark = (rx_level >= rx_mark);
  always_comb begin
    unique case (rx_thr)
      ufs_pkg::TRIG_00: rx_mark = 5'h01;
      ufs_pkg::TRIG_01: rx_mark = ufs_pkg::FIFO_DEPTH >> 2;
      ufs_pkg::TRIG_10: rx_mark = ufs_pkg::FIFO_DEPTH >> 1;
      ufs_pkg::TRIG_11: rx_mark = ufs_pkg::FIFO_DEPTH - 5'h02;
    endcase
  end
  always_comb begin
    unique case (tx_thr)
      ufs_pkg::TRIG_00: tx_mark = 5'h00;
      ufs_pkg::TRIG_01: tx_mark = 5'h02;
      ufs_pkg::TRIG_10: tx_mark = ufs_pkg::FIFO_DEPTH >> 2;
      ufs_pkg::TRIG_11: tx_mark = ufs_pkg::FIFO_DEPTH >> 1;
    endcase
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rx_trigger_hit <= 1'b0;
      transmit_holding_empty_event <= 1'b0;
      dma_rx_req_n <= 1'b1;
    end else begin
      rx_trigger_hit <= fifo_en ? rx_at_mark : (rx_level != 5'h00);
      transmit_holding_empty_event <= fifo_en ? (tx_level <= tx_mark) : (tx_level == 5'h00);
      if (dma_mode && fifo_en) begin
        dma_rx_req_n <= !rx_at_mark;
      end else begin
        dma_rx_req_n <= (rx_level == 5'h00);
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  logic [ufs_pkg::IRQ_W-1:0] int_status, int_mask, int_event;
  logic rx_hit_d, tx_evt_d;
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rx_hit_d <= 1'b0;
      tx_evt_d <= 1'b0;
    end else begin
      rx_hit_d <= rx_trigger_hit;
      tx_evt_d <= transmit_holding_empty_event;
    end
  end
  always_comb begin
    int_event = '0;
    int_event[ufs_pkg::IRQ_RX_AVAIL] = rx_trigger_hit && !rx_hit_d;
    int_event[ufs_pkg::IRQ_TX_EMPTY] = transmit_holding_empty_event && !tx_evt_d;
    int_event[ufs_pkg::IRQ_FIFO_RST] = fifo_reset_pulse;
  end
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      int_status <= '0;
    end else begin
      int_status <= (int_status & ~(wr_stat ? reg_wdata[ufs_pkg::IRQ_W-1:0] : '0)) | int_event;
    end
  end
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      int_mask <= '0;
    end else if (wr_mask) begin
      int_mask <= reg_wdata[ufs_pkg::IRQ_W-1:0];
    end
  end
  assign irq = |(int_status & int_mask);

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  logic [ufs_pkg::DATA_W-1:0] next_rdata;
  always_comb begin
    next_rdata = '0;
    unique case (reg_addr)
      ufs_pkg::OFS_DMA_MODE: next_rdata[0] = dma_mode;
      ufs_pkg::OFS_FIFO_EN: next_rdata[0] = fifo_en;
      ufs_pkg::OFS_RX_THR: next_rdata[1:0] = rx_thr;
      ufs_pkg::OFS_TX_THR: next_rdata[1:0] = tx_thr;
      ufs_pkg::OFS_TX_HOLD: next_rdata[0] = tx_hold;
      ufs_pkg::OFS_INT_STATUS: next_rdata[ufs_pkg::IRQ_W-1:0] = int_status;
      ufs_pkg::OFS_INT_MASK: next_rdata[ufs_pkg::IRQ_W-1:0] = int_mask;
      ufs_pkg::OFS_BUILD: next_rdata = ufs_pkg::BUILD_RESET;
      ufs_pkg::OFS_VERSION: next_rdata = ufs_pkg::VERSION_ID;
      ufs_pkg::OFS_TYPE: next_rdata = ufs_pkg::TYPE_ID;
      default: next_rdata = '0;
    endcase
  end
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= '0;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_dma_field;
    @(posedge clock) disable iff (!rst_sync_n)
    wr_dma |=> (dma_mode == $past(reg_wdata[0])) && (rx_thr == $past(rx_thr));
  endproperty
  a_dma_field: assert property (p_dma_field) else $error("dma mode write wrong");

  property p_fe_field;
    @(posedge clock) disable iff (!rst_sync_n)
    wr_fe |=> (fifo_en == $past(reg_wdata[0])) && (tx_thr == $past(tx_thr));
  endproperty
  a_fe_field: assert property (p_fe_field) else $error("fifo enable write wrong");

  property p_keep_other;
    @(posedge clock) disable iff (!rst_sync_n)
    wr_rx |=> (fifo_control_word[5:0] == $past(fifo_control_word[5:0]));
  endproperty
  a_keep_other: assert property (p_keep_other) else $error("other field changed");

  property p_fifo_reset;
    @(posedge clock) disable iff (!rst_sync_n)
    $fell(fifo_en) |-> fifo_reset_pulse ##1 !fifo_reset_pulse;
  endproperty
  a_fifo_reset: assert property (p_fifo_reset) else $error("no fifo reset on disable");

  property p_rx_thr;
    @(posedge clock) disable iff (!rst_sync_n)
    wr_rx |=> rx_thr == $past(reg_wdata[1:0]);
  endproperty
  a_rx_thr: assert property (p_rx_thr) else $error("rx trigger not stored");

  property p_rx_full_mark;
    @(posedge clock) disable iff (!rst_sync_n)
    (fifo_en && rx_thr == ufs_pkg::TRIG_11 && rx_level == 5'h0e) |=> rx_trigger_hit;
  endproperty
  a_rx_full_mark: assert property (p_rx_full_mark) else $error("rx trigger 11 missed");

  property p_dma_req;
    @(posedge clock) disable iff (!rst_sync_n)
    (dma_mode && fifo_en) |=> (dma_rx_req_n == !$past(rx_at_mark));
  endproperty
  a_dma_req: assert property (p_dma_req) else $error("dma request level wrong");

  property p_tx_thr;
    @(posedge clock) disable iff (!rst_sync_n)
    wr_tx |=> tx_thr == $past(reg_wdata[1:0]);
  endproperty
  a_tx_thr: assert property (p_tx_thr) else $error("tx trigger not stored");

  property p_tx_two;
    @(posedge clock) disable iff (!rst_sync_n)
    (fifo_en && tx_thr == ufs_pkg::TRIG_01 && tx_level == 5'h03) |=> !transmit_holding_empty_event;
  endproperty
  a_tx_two: assert property (p_tx_two) else $error("tx trigger 01 wrong");

  property p_halt;
    @(posedge clock) disable iff (!rst_sync_n)
    (tx_hold && fifo_en) |-> !tx_start_allowed;
  endproperty
  a_halt: assert property (p_halt) else $error("start while halted");

  property p_halt_off;
    @(posedge clock) disable iff (!rst_sync_n)
    !fifo_en |-> (tx_start_allowed == tx_start_request);
  endproperty
  a_halt_off: assert property (p_halt_off) else $error("halt acted without fifo");

  property p_id_ro;
    @(posedge clock) disable iff (!rst_sync_n)
    (reg_read && reg_addr == ufs_pkg::OFS_TYPE) |=> reg_rdata == ufs_pkg::TYPE_ID;
  endproperty
  a_id_ro: assert property (p_id_ro) else $error("type word changed");

  property p_tx_keep;
    @(posedge clock) disable iff (!rst_sync_n)
    wr_tx |=> (rx_thr == $past(rx_thr)) && (fifo_en == $past(fifo_en))
      && (dma_mode == $past(dma_mode));
  endproperty
  a_tx_keep: assert property (p_tx_keep) else $error("tx trigger write touched other field");

  property p_fe_keep;
    @(posedge clock) disable iff (!rst_sync_n)
    wr_fe |=> (rx_thr == $past(rx_thr)) && (dma_mode == $past(dma_mode));
  endproperty
  a_fe_keep: assert property (p_fe_keep) else $error("fifo enable write touched other field");

  property p_hold_keep;
    @(posedge clock) disable iff (!rst_sync_n)
    wr_hold |=> fifo_control_word == $past(fifo_control_word);
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("halt write touched control word");

  property p_pulse_cause;
    @(posedge clock) disable iff (!rst_sync_n)
    fifo_reset_pulse |-> $fell(fifo_en);
  endproperty
  a_pulse_cause: assert property (p_pulse_cause) else $error("fifo reset without disable");

  property p_pulse_status;
    @(posedge clock) disable iff (!rst_sync_n)
    fifo_reset_pulse |=> int_status[ufs_pkg::IRQ_FIFO_RST];
  endproperty
  a_pulse_status: assert property (p_pulse_status) else $error("fifo reset not flagged");

  property p_rx_off;
    @(posedge clock) disable iff (!rst_sync_n)
    (!fifo_en && rx_level == 5'h01) |=> rx_trigger_hit;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx data missed with fifo off");

  property p_rx_one;
    @(posedge clock) disable iff (!rst_sync_n)
    (fifo_en && rx_thr == ufs_pkg::TRIG_00 && rx_level == 5'h01) |=> rx_trigger_hit;
  endproperty
  a_rx_one: assert property (p_rx_one) else $error("rx trigger 00 missed");

  property p_rx_quarter;
    @(posedge clock) disable iff (!rst_sync_n)
    (fifo_en && rx_thr == ufs_pkg::TRIG_01 && rx_level == 5'h03) |=> !rx_trigger_hit;
  endproperty
  a_rx_quarter: assert property (p_rx_quarter) else $error("rx trigger 01 early");

  property p_rx_half;
    @(posedge clock) disable iff (!rst_sync_n)
    (fifo_en && rx_thr == ufs_pkg::TRIG_10 && rx_level == 5'h08) |=> rx_trigger_hit;
  endproperty
  a_rx_half: assert property (p_rx_half) else $error("rx trigger 10 missed");

  property p_dma_idle;
    @(posedge clock) disable iff (!rst_sync_n)
    !(dma_mode && fifo_en) |=> dma_rx_req_n == ($past(rx_level) == 5'h00);
  endproperty
  a_dma_idle: assert property (p_dma_idle) else $error("single request level wrong");

  property p_tx_empty;
    @(posedge clock) disable iff (!rst_sync_n)
    (fifo_en && tx_thr == ufs_pkg::TRIG_00 && tx_level == 5'h01) |=> !transmit_holding_empty_event;
  endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("tx trigger 00 early");

  property p_tx_two_at;
    @(posedge clock) disable iff (!rst_sync_n)
    (fifo_en && tx_thr == ufs_pkg::TRIG_01 && tx_level == 5'h02) |=> transmit_holding_empty_event;
  endproperty
  a_tx_two_at: assert property (p_tx_two_at) else $error("tx trigger 01 missed");

  property p_tx_half;
    @(posedge clock) disable iff (!rst_sync_n)
    (fifo_en && tx_thr == ufs_pkg::TRIG_11 && tx_level == 5'h08) |=> transmit_holding_empty_event;
  endproperty
  a_tx_half: assert property (p_tx_half) else $error("tx trigger 11 missed");

  property p_hold_store;
    @(posedge clock) disable iff (!rst_sync_n)
    wr_hold |=> tx_hold == $past(reg_wdata[0]);
  endproperty
  a_hold_store: assert property (p_hold_store) else $error("halt bit not stored");

  property p_reserved;
    @(posedge clock) disable iff (!rst_sync_n)
    (reg_read && reg_addr == ufs_pkg::OFS_RX_THR) |=> reg_rdata[ufs_pkg::DATA_W-1:2] == '0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

  property p_rdata_idle;
    @(posedge clock) disable iff (!rst_sync_n)
    !reg_read |=> reg_rdata == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");

  c_fifo_off: cover property (@(posedge clock) disable iff (!rst_sync_n) fifo_reset_pulse);
  c_dma_req: cover property (@(posedge clock) disable iff (!rst_sync_n) dma_mode && !dma_rx_req_n);
  c_halt: cover property (@(posedge clock) disable iff (!rst_sync_n) tx_hold && tx_start_request);
  c_irq: cover property (@(posedge clock) disable iff (!rst_sync_n) irq);
  c_rx_near_full: cover property (@(posedge clock) disable iff (!rst_sync_n)
    rx_trigger_hit && rx_thr == ufs_pkg::TRIG_11);
endmodule // ufs_shadow
`default_nettype wire

/* File: tb/ufs_fifo_model.sv */
/*
  Far-side UART FIFO model: receive and transmit fill counters.
  Assumes the bench pushes characters on the block clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ufs_fifo_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic rx_push,
  input wire logic tx_push,
  input wire logic fifo_reset_pulse,
  input wire logic tx_start_allowed,
  output logic [ufs_pkg::LEVEL_W-1:0] rx_level,
  output logic [ufs_pkg::LEVEL_W-1:0] tx_level,
  output logic tx_start_request
);
  assign tx_start_request = (tx_level != 5'h00);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_level <= 5'h00;
      tx_level <= 5'h00;
    end else if (fifo_reset_pulse) begin
      rx_level <= 5'h00;
      tx_level <= 5'h00;
    end else begin
      if (rx_push && rx_level != ufs_pkg::FIFO_DEPTH) rx_level <= rx_level + 5'h01;
      tx_level <= tx_level + 5'(tx_push) - 5'(tx_start_allowed);
    end
  end
endmodule // ufs_fifo_model
`default_nettype wire

/* File: tb/ufs_shadow_test.sv */
/*
  Self-checking bench for the UART FIFO shadow controls.
  Assumes the design package and the far-side FIFO model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module ufs_shadow_test;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] reg_addr = 32'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic rx_push = 1'b0;
  logic tx_push = 1'b0;
  logic [15:0] reg_rdata;
  logic [4:0] rx_level;
  logic [4:0] tx_level;
  logic [7:0] fcw;
  logic tx_req, pulse, tx_ok, rx_hit, tx_event, req_n, irq;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  int rx_mark[4] = '{1, 4, 8, 14};
  int tx_mark[4] = '{0, 2, 4, 8};
  logic [31:0] ofs[8] = '{ufs_pkg::OFS_DMA_MODE, ufs_pkg::OFS_FIFO_EN, ufs_pkg::OFS_RX_THR,
    ufs_pkg::OFS_TX_THR, ufs_pkg::OFS_TX_HOLD, ufs_pkg::OFS_BUILD, ufs_pkg::OFS_VERSION,
    ufs_pkg::OFS_TYPE};
  logic [15:0] ids[3] = '{ufs_pkg::BUILD_RESET, ufs_pkg::VERSION_ID, ufs_pkg::TYPE_ID};
  logic [15:0] live[8] = '{16'h1, 16'h1, 16'h3, 16'h3, 16'h1, 16'h0, 16'h0, 16'h0};

  ufs_shadow DUT (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .rx_level(rx_level),
    .tx_level(tx_level), .tx_start_request(tx_req), .fifo_control_word(fcw),
    .fifo_reset_pulse(pulse), .tx_start_allowed(tx_ok), .rx_trigger_hit(rx_hit),
    .transmit_holding_empty_event(tx_event), .dma_rx_req_n(req_n), .irq(irq));
  ufs_fifo_model far_end (.clock(clock), .rst_n(rst_n), .rx_push(rx_push), .tx_push(tx_push),
    .fifo_reset_pulse(pulse), .tx_start_allowed(tx_ok), .rx_level(rx_level),
    .tx_level(tx_level), .tx_start_request(tx_req));

  // ----------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------
  always #20 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rdchk(input string what, input logic [31:0] a, input logic [15:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    check(what, reg_rdata, exp);
  endtask
  task automatic wfc(input logic [31:0] a, input logic [15:0] d, input logic [7:0] e);
    wr(a, d);
    settle(1);
    check("control word", 16'(fcw), 16'(e));
  endtask
  task automatic push(input logic rx, input int n);
    if (n == 0) return;
    @(posedge clock);
    if (rx) rx_push <= 1'b1;
    else tx_push <= 1'b1;
    repeat (n) @(posedge clock);
    rx_push <= 1'b0;
    tx_push <= 1'b0;
  endtask
  task automatic flush();
    wr(ufs_pkg::OFS_FIFO_EN, 16'h0);
    wr(ufs_pkg::OFS_FIFO_EN, 16'h1);
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    settle(3);
    check("request idle", 16'(req_n), 16'h1);
    for (int i = 0; i < 8; i++) rdchk("reset value", ofs[i], (i < 5) ? 16'h0 : ids[i - 5]);
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      wr(ofs[i], 16'hffff);
      rdchk("read back", ofs[i], (i < 5) ? live[i] : ids[i - 5]);
    end
    rdchk("unmapped", 32'h500011f0, 16'h0);
    settle(1);
    check("control word", 16'(fcw), 16'h00f9);
    $display("register access done");
    wr(ufs_pkg::OFS_FIFO_EN, 16'h0);
    #1;
    check("reset pulse", 16'(pulse), 16'h1);
    settle(1);
    check("reset pulse", 16'(pulse), 16'h0);
    check("control word", 16'(fcw), 16'h00f8);
    wfc(ufs_pkg::OFS_DMA_MODE, 16'h0, 8'hf0);
    wfc(ufs_pkg::OFS_RX_THR, 16'h1, 8'h70);
    wfc(ufs_pkg::OFS_TX_THR, 16'h2, 8'h60);
    wfc(ufs_pkg::OFS_FIFO_EN, 16'h1, 8'h61);
    wfc(ufs_pkg::OFS_DMA_MODE, 16'h1, 8'h69);
    $display("field isolation done");
    for (int c = 0; c < 4; c++) begin
      wr(ufs_pkg::OFS_RX_THR, 16'(c));
      flush();
      push(1'b1, rx_mark[c] - 1);
      settle(3);
      check("rx below", 16'(rx_hit), 16'h0);
      check("dma below", 16'(req_n), 16'h1);
      push(1'b1, 1);
      settle(3);
      check("rx at mark", 16'(rx_hit), 16'h1);
      check("dma at mark", 16'(req_n), 16'h0);
    end
    $display("receive trigger done");
    for (int c = 0; c < 4; c++) begin
      wr(ufs_pkg::OFS_TX_THR, 16'(c));
      flush();
      for (int k = 0; k <= tx_mark[c] + 1; k++) begin
        settle(3);
        check("tx event", 16'(tx_event), 16'(k <= tx_mark[c]));
        check("tx held", 16'(tx_level), 16'(k));
        push(1'b0, 1);
      end
    end
    wr(ufs_pkg::OFS_FIFO_EN, 16'h0);
    push(1'b0, 3);
    settle(4);
    check("tx drained", 16'(tx_level), 16'h0);
    $display("transmit side done");
    wr(ufs_pkg::OFS_INT_STATUS, 16'h7);
    flush();
    wr(ufs_pkg::OFS_FIFO_EN, 16'h0);
    settle(2);
    check("irq masked", 16'(irq), 16'h0);
    rdchk("status", ufs_pkg::OFS_INT_STATUS, 16'h4);
    wr(ufs_pkg::OFS_INT_MASK, 16'h4);
    settle(1);
    check("irq raised", 16'(irq), 16'h1);
    rdchk("mask", ufs_pkg::OFS_INT_MASK, 16'h4);
    wr(ufs_pkg::OFS_INT_STATUS, 16'h4);
    settle(1);
    check("irq cleared", 16'(irq), 16'h0);
    rdchk("status cleared", ufs_pkg::OFS_INT_STATUS, 16'h0);
    $display("interrupt done");
    print_verdict();
  end
endmodule // ufs_shadow_test
`default_nettype wire
